/* File: design/wsq_consts.svh */
// Constants for the weld schedule sequencer: table layout, codes, offsets.
// Assumes inclusion by bare name from the sequencer design files.
`ifndef WSQ_CONSTS_SVH
`define WSQ_CONSTS_SVH

// Field index inside one schedule entry
`define WSQ_F_SQZ 4'h0
`define WSQ_F_WELD 4'h1
`define WSQ_F_PCT 4'h2
`define WSQ_F_HOLD 4'h3
`define WSQ_F_OFF 4'h4
`define WSQ_F_IMP 4'h5
`define WSQ_F_COOL 4'h6
`define WSQ_F_VALVE 4'h7
`define WSQ_F_CYC 4'h8
`define WSQ_F_SLM 4'h9
`define WSQ_F_SLC 4'ha
`define WSQ_F_LAST 4'ha

// Cycle mode codes
`define WSQ_CM_REPEAT 8'h01
`define WSQ_CM_CHAIN 8'h02
`define WSQ_CM_SUCC 8'h03

// Slope mode codes
`define WSQ_SL_UP 8'h01
`define WSQ_SL_DN 8'h02

// Valve code that selects only the third valve
`define WSQ_VALVE3_ONLY 8'h04

// Register port: bit 10 set selects control space
`define WSQ_A_CTL_BIT 10
`define WSQ_A_SEL 11'h400
`define WSQ_A_STAT 11'h401
`define WSQ_A_DISP 11'h402

// Status bit positions
`define WSQ_ST_BUSY 7
`define WSQ_ST_FLASH 6
`define WSQ_ST_WELD 5

// Reset values
`define WSQ_RST_SEL 6'h00
`define WSQ_RST_BYTE 8'h00
`define WSQ_RST_VALVE 3'h0
`define WSQ_ONE_IMP 8'h01

`endif

/* File: design/wsq_pkg.sv */
// Types shared by the weld schedule sequencer modules.
// Assumes compilation before every other sequencer file.
package wsq_pkg;

    // Sequencer states, one-hot
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_LOAD = 10'h002,
        ST_SQZ = 10'h004,
        ST_UP = 10'h008,
        ST_WELD = 10'h010,
        ST_COOL = 10'h020,
        ST_DN = 10'h040,
        ST_HOLD = 10'h080,
        ST_OFF = 10'h100,
        ST_WAIT = 10'h200
    } wsq_state_e;

    typedef logic [7:0] wsq_byte_t;

endpackage : wsq_pkg

/* File: design/wsq_in_if.sv */
// Conditioned initiation and line-cycle signals between input stage
// and sequencer. Assumes both ends run on the core clock.
`timescale 1ns/100ps
interface wsq_in_if;
    logic init_lvl;
    logic init_rise;
    logic line_tick;

    modport cond (output init_lvl, output init_rise, output line_tick);
    modport seq (input init_lvl, input init_rise, input line_tick);
endinterface : wsq_in_if

/* File: design/wsq_in_cond.sv */
// Input stage: synchronises the initiation switch and the mains line
// reference, and makes one-clock pulses on their filtered rising edges.
// Assumes both pins are asynchronous to the core clock.
`timescale 1ns/100ps
module wsq_in_cond
    import wsq_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic init_pin,
    input wire logic line_pin,
    wsq_in_if.cond io
);
    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic [1:0] s3_reg;
    logic [1:0] lvl_reg;
    logic [1:0] lvl_next;
    logic [1:0] rise_reg;

    // Three-stage synchroniser chain
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_reg <= 2'h0;
            s2_reg <= 2'h0;
            s3_reg <= 2'h0;
        end else begin
            s1_reg <= {line_pin, init_pin};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Level changes only once stages two and three agree
    always_comb begin
        lvl_next = lvl_reg;
        for (int i = 0; i < 2; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                lvl_next[i] = s3_reg[i];
            end
        end
    end

    // Filtered level and rising-edge pulses
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lvl_reg <= 2'h0;
            rise_reg <= 2'h0;
        end else begin
            lvl_reg <= lvl_next;
            rise_reg <= lvl_next & ~lvl_reg;
        end
    end

    assign io.init_lvl = lvl_reg[0];
    assign io.init_rise = rise_reg[0];
    assign io.line_tick = rise_reg[1];
endmodule : wsq_in_cond

/* File: design/wsq_top.sv */
// Weld schedule sequencer: steps through stored schedules counted in
// line cycles, drives valves and the weld contactor with percent heat.
// Assumes a register master on the core clock and asynchronous pins.
`timescale 1ns/100ps
`include "wsq_consts.svh"
module wsq_top
    import wsq_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic INIT_SW,
    input wire logic LINE_SYNC,
    input wire logic [10:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic [2:0] VALVE,
    output logic WELD_ON,
    output logic [7:0] HEAT_PCT,
    output logic [5:0] SCHED_NUM,
    output logic SCHED_FLASH,
    output logic BUSY
);
    wsq_in_if in_if();

    wsq_byte_t mem [0:1023];
    wsq_state_e state_reg;
    wsq_state_e state_next;
    wsq_byte_t cnt_reg;
    wsq_byte_t cnt_next;
    wsq_byte_t imp_reg;
    wsq_byte_t prev_pct_reg;
    wsq_byte_t heat_reg;
    wsq_byte_t rdata_reg;
    logic [5:0] sel_reg;
    logic [5:0] cur_reg;
    logic [5:0] pair_reg;
    logic [5:0] nxt_idx;
    logic succ_reg;
    logic carry_reg;
    logic weld_on_reg;
    logic flash_reg;
    logic [2:0] valve_reg;
    logic hold_done;
    logic cont_ok;
    logic final_end;
    wsq_byte_t c_sqz, c_weld, c_pct, c_hold, c_off, c_imp, c_cool;
    wsq_byte_t c_valve, c_cyc, c_slm, c_slc, n_sqz, n_pct, n_slm;

    wsq_in_cond u_in (
        .clk (CORE_CLK),
        .rstn (RESETN),
        .init_pin (INIT_SW),
        .line_pin (LINE_SYNC),
        .io (in_if.cond)
    );

    // One field of one schedule entry
    function automatic wsq_byte_t fld(input logic [5:0] s,
                                      input logic [3:0] f);
        return mem[{s, f}];
    endfunction : fld

    // Linear ramp from a to b, step n of c
    function automatic wsq_byte_t ramp(input wsq_byte_t a,
                                       input wsq_byte_t b,
                                       input wsq_byte_t n,
                                       input wsq_byte_t c);
        logic signed [17:0] diff;
        logic signed [17:0] step;
        logic signed [17:0] sum;
        diff = $signed({10'h000, b}) - $signed({10'h000, a});
        step = 18'(diff * $signed({10'h000, n}));
        step = step / $signed({10'h000, c});
        sum = $signed({10'h000, a}) + step;
        return (c == `WSQ_RST_BYTE) ? b : sum[7:0];
    endfunction : ramp

    // Current and following schedule fields
    assign nxt_idx = cur_reg + 6'h01;
    assign c_sqz = fld(cur_reg, `WSQ_F_SQZ);
    assign c_weld = fld(cur_reg, `WSQ_F_WELD);
    assign c_pct = fld(cur_reg, `WSQ_F_PCT);
    assign c_hold = fld(cur_reg, `WSQ_F_HOLD);
    assign c_off = fld(cur_reg, `WSQ_F_OFF);
    assign c_imp = fld(cur_reg, `WSQ_F_IMP);
    assign c_cool = fld(cur_reg, `WSQ_F_COOL);
    assign c_valve = fld(cur_reg, `WSQ_F_VALVE);
    assign c_cyc = fld(cur_reg, `WSQ_F_CYC);
    assign c_slm = fld(cur_reg, `WSQ_F_SLM);
    assign c_slc = fld(cur_reg, `WSQ_F_SLC);
    assign n_sqz = fld(nxt_idx, `WSQ_F_SQZ);
    assign n_pct = fld(nxt_idx, `WSQ_F_PCT);
    assign n_slm = fld(nxt_idx, `WSQ_F_SLM);

    // Sequence end points and continuous-current condition
    assign hold_done = (state_reg == ST_HOLD) && (cnt_reg == '0);
    assign final_end = hold_done && (c_cyc != `WSQ_CM_CHAIN)
                       && (c_cyc != `WSQ_CM_SUCC)
                       && (c_cyc != `WSQ_CM_REPEAT);
    assign cont_ok = (c_cool == '0) && (imp_reg <= `WSQ_ONE_IMP)
                     && (c_slm != `WSQ_SL_DN) && (c_hold == '0)
                     && (c_cyc == `WSQ_CM_CHAIN) && (n_sqz == '0)
                     && (n_slm != `WSQ_SL_UP);

    // Schedule table and select register writes
    always_ff @(posedge CORE_CLK) begin
        if (REG_WR && !REG_ADDR[`WSQ_A_CTL_BIT]) begin
            mem[REG_ADDR[9:0]] <= REG_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            sel_reg <= `WSQ_RST_SEL;
        end else if (REG_WR && REG_ADDR == `WSQ_A_SEL) begin
            sel_reg <= REG_WDATA[5:0];
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            rdata_reg <= `WSQ_RST_BYTE;
        end else if (REG_RD) begin
            if (!REG_ADDR[`WSQ_A_CTL_BIT]) begin
                rdata_reg <= mem[REG_ADDR[9:0]];
            end else if (REG_ADDR == `WSQ_A_SEL) begin
                rdata_reg <= {2'h0, sel_reg};
            end else if (REG_ADDR == `WSQ_A_STAT) begin
                rdata_reg <= `WSQ_RST_BYTE;
                rdata_reg[`WSQ_ST_BUSY] <= BUSY;
                rdata_reg[`WSQ_ST_FLASH] <= flash_reg;
                rdata_reg[`WSQ_ST_WELD] <= weld_on_reg;
                rdata_reg[2:0] <= valve_reg;
            end else if (REG_ADDR == `WSQ_A_DISP) begin
                rdata_reg <= {2'h0, cur_reg};
            end else begin
                rdata_reg <= `WSQ_RST_BYTE;
            end
        end else begin
            rdata_reg <= `WSQ_RST_BYTE;
        end
    end

    // Phase sequencing; a zero count phase passes in one clock
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        if (cnt_reg != '0) begin
            if (in_if.line_tick) begin
                cnt_next = cnt_reg - 8'h01;
            end
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_WAIT: begin
                    if (in_if.init_rise) begin
                        state_next = ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    state_next = ST_SQZ;
                    cnt_next = c_sqz;
                end
                ST_SQZ: begin
                    if (c_slm == `WSQ_SL_UP) begin
                        state_next = ST_UP;
                        cnt_next = c_slc;
                    end else begin
                        state_next = ST_WELD;
                        cnt_next = c_weld;
                    end
                end
                ST_UP: begin
                    state_next = ST_WELD;
                    cnt_next = c_weld;
                end
                ST_WELD: begin
                    state_next = ST_COOL;
                    cnt_next = c_cool;
                end
                ST_COOL: begin
                    if (imp_reg > `WSQ_ONE_IMP) begin
                        state_next = ST_WELD;
                        cnt_next = c_weld;
                    end else if (c_slm == `WSQ_SL_DN) begin
                        state_next = ST_DN;
                        cnt_next = c_slc;
                    end else begin
                        state_next = ST_HOLD;
                        cnt_next = c_hold;
                    end
                end
                ST_DN: begin
                    state_next = ST_HOLD;
                    cnt_next = c_hold;
                end
                ST_HOLD: begin
                    if (c_cyc == `WSQ_CM_CHAIN) begin
                        state_next = ST_LOAD;
                    end else if (c_cyc == `WSQ_CM_SUCC) begin
                        state_next = ST_WAIT;
                    end else if (c_cyc == `WSQ_CM_REPEAT) begin
                        state_next = ST_OFF;
                        cnt_next = c_off;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
                ST_OFF: begin
                    state_next = in_if.init_lvl ? ST_LOAD : ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            state_reg <= ST_IDLE;
            cnt_reg <= `WSQ_RST_BYTE;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Impulse counter, loaded per schedule
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            imp_reg <= `WSQ_ONE_IMP;
        end else if (state_reg == ST_LOAD) begin
            imp_reg <= c_imp;
        end else if (state_reg == ST_COOL && cnt_reg == '0
                     && imp_reg > `WSQ_ONE_IMP) begin
            imp_reg <= imp_reg - 8'h01;
        end
    end

    // Schedule index, successive pair and previous percent
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            cur_reg <= `WSQ_RST_SEL;
            pair_reg <= `WSQ_RST_SEL;
            succ_reg <= 1'b0;
            prev_pct_reg <= `WSQ_RST_BYTE;
        end else if (hold_done && c_cyc == `WSQ_CM_CHAIN) begin
            cur_reg <= nxt_idx;
            prev_pct_reg <= c_pct;
        end else if (hold_done && c_cyc == `WSQ_CM_SUCC) begin
            cur_reg <= nxt_idx;
            if (!succ_reg) begin
                pair_reg <= cur_reg;
                succ_reg <= 1'b1;
            end
        end else if (final_end && succ_reg) begin
            cur_reg <= pair_reg;
            succ_reg <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            prev_pct_reg <= `WSQ_RST_BYTE;
            if (!succ_reg) begin
                cur_reg <= sel_reg;
            end
        end
    end

    // Current carried across a schedule change
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            carry_reg <= 1'b0;
        end else if (state_reg == ST_WELD && cnt_reg == '0
                     && cont_ok) begin
            carry_reg <= 1'b1;
        end else if (state_reg == ST_WELD || state_reg == ST_IDLE) begin
            carry_reg <= 1'b0;
        end
    end

    // Valves accumulate over a chain, all drop at the sequence end
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            valve_reg <= `WSQ_RST_VALVE;
        end else if (state_next == ST_IDLE || state_next == ST_WAIT
                     || state_next == ST_OFF) begin
            valve_reg <= `WSQ_RST_VALVE;
        end else if (state_reg == ST_LOAD) begin
            valve_reg <= valve_reg | c_valve[2:0];
        end
    end

    // Contactor, heat level and display flash
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            weld_on_reg <= 1'b0;
            heat_reg <= `WSQ_RST_BYTE;
            flash_reg <= 1'b0;
        end else begin
            weld_on_reg <= (state_reg == ST_WELD) || (state_reg == ST_UP)
                           || (state_reg == ST_DN) || carry_reg;
            flash_reg <= (state_next == ST_WAIT);
            if (state_reg == ST_UP) begin
                heat_reg <= ramp(prev_pct_reg, c_pct, c_slc - cnt_reg,
                                 c_slc);
            end else if (state_reg == ST_DN) begin
                heat_reg <= ramp(c_pct, n_pct, c_slc - cnt_reg,
                                 c_slc);
            end else if (state_reg == ST_WELD) begin
                heat_reg <= c_pct;
            end else if (!carry_reg) begin
                heat_reg <= `WSQ_RST_BYTE;
            end
        end
    end

    assign REG_RDATA = rdata_reg;
    assign VALVE = valve_reg;
    assign WELD_ON = weld_on_reg;
    assign HEAT_PCT = heat_reg;
    assign SCHED_NUM = cur_reg;
    assign SCHED_FLASH = flash_reg;
    assign BUSY = (state_reg != ST_IDLE) && (state_reg != ST_WAIT);

    // Checks on sequencing behaviour
    property p_succ_wait;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (hold_done && c_cyc == `WSQ_CM_SUCC)
            |=> (state_reg == ST_WAIT && SCHED_FLASH && !WELD_ON);
    endproperty
    a_succ_wait: assert property (p_succ_wait)
        else $error("successive end did not flash and wait");

    property p_succ_return;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (final_end && succ_reg) |=> (SCHED_NUM == $past(pair_reg));
    endproperty
    a_succ_return: assert property (p_succ_return)
        else $error("pair did not return to first schedule");

    property p_chain_adv;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (hold_done && c_cyc == `WSQ_CM_CHAIN)
            |=> (state_reg == ST_LOAD)
                && (SCHED_NUM == $past(cur_reg) + 6'h01);
    endproperty
    a_chain_adv: assert property (p_chain_adv)
        else $error("chain did not advance");

    property p_quench;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (state_reg == ST_HOLD && !carry_reg) |=> !WELD_ON;
    endproperty
    a_quench: assert property (p_quench)
        else $error("current on during hold");

    property p_temper;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (state_reg == ST_WELD) |=> (HEAT_PCT == $past(c_pct)) && WELD_ON;
    endproperty
    a_temper: assert property (p_temper)
        else $error("weld not at its own percent");

    property p_upslope;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (state_reg == ST_UP && cnt_reg == '0)
            |=> (HEAT_PCT == $past(c_pct));
    endproperty
    a_upslope: assert property (p_upslope)
        else $error("upslope did not reach target");

    property p_dnslope;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (state_reg == ST_DN && cnt_reg == '0)
            |=> (HEAT_PCT == $past(n_pct));
    endproperty
    a_dnslope: assert property (p_dnslope)
        else $error("downslope did not reach next percent");

    property p_valve_keep;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (state_reg == ST_LOAD) |=> ((VALVE & $past(VALVE)) == $past(VALVE))
            && ((VALVE & $past(c_valve[2:0])) == $past(c_valve[2:0]));
    endproperty
    a_valve_keep: assert property (p_valve_keep)
        else $error("valve dropped or not added at schedule start");

    property p_valve_off;
        @(posedge CORE_CLK) disable iff (!RESETN)
        final_end |=> (VALVE == `WSQ_RST_VALVE);
    endproperty
    a_valve_off: assert property (p_valve_off)
        else $error("valves still on after final hold");

    property p_valve3;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (state_reg == ST_LOAD && c_valve == `WSQ_VALVE3_ONLY
         && VALVE == `WSQ_RST_VALVE) |=> (VALVE == 3'h4);
    endproperty
    a_valve3: assert property (p_valve3)
        else $error("code 04 did not drive only valve 3");

    property p_carry;
        @(posedge CORE_CLK) disable iff (!RESETN)
        carry_reg |=> WELD_ON;
    endproperty
    a_carry: assert property (p_carry)
        else $error("current broke across chained schedules");

    property p_impulse;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (state_reg == ST_COOL && cnt_reg == '0 && imp_reg > `WSQ_ONE_IMP)
            |=> (state_reg == ST_WELD) ##1 WELD_ON;
    endproperty
    a_impulse: assert property (p_impulse)
        else $error("impulse did not repeat weld");
endmodule : wsq_top

/* File: tb/wsq_far_model.sv */
// Far side model: initiation switch, free-running mains reference,
// and a counter of contactor closures. Assumes the core clock domain.
`timescale 1ns/100ps
module wsq_far_model #(
    parameter int LINE_CLKS = 40
) (
    input wire logic clk,
    input wire logic init_cmd,
    input wire logic clr,
    input wire logic weld_on,
    output logic init_sw,
    output logic line_sync,
    output logic [7:0] pulses
);
    int ph = 0;
    logic weld_d = 1'b0;

    // Switch follows the bench's press command
    assign init_sw = init_cmd;

    // Mains reference runs free, half period high
    always @(posedge clk) begin
        ph <= (ph == LINE_CLKS - 1) ? 0 : ph + 1;
        line_sync <= (ph < LINE_CLKS / 2);
    end

    // Count contactor closures
    always @(posedge clk) begin
        weld_d <= weld_on;
        if (clr) begin
            pulses <= 8'h00;
        end else if (weld_on && !weld_d) begin
            pulses <= pulses + 8'h01;
        end
    end
endmodule : wsq_far_model

/* File: tb/tb_weld_schedule_sequencer.sv */
// Bench for the weld schedule sequencer: register tasks, schedule loads,
// presses of the initiation switch. Assumes the far side model file.
`timescale 1ns/100ps
`include "wsq_consts.svh"
module tb_weld_schedule_sequencer;
    logic CORE_CLK = 1'b0, RESETN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
    logic [10:0] REG_ADDR = 11'h000;
    logic [7:0] REG_WDATA = 8'h00, REG_RDATA, HEAT_PCT, pulses;
    logic [2:0] VALVE;
    logic [5:0] SCHED_NUM;
    logic WELD_ON, SCHED_FLASH, BUSY, INIT_SW, LINE_SYNC;
    logic init_cmd = 1'b0, clr = 1'b0;
    int n_errors = 0, n_checks = 0;
    logic seen_up = 1'b0, seen_dn = 1'b0;

    wsq_top wsq_top_inst (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
        .INIT_SW(INIT_SW), .LINE_SYNC(LINE_SYNC), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .VALVE(VALVE), .WELD_ON(WELD_ON),
        .HEAT_PCT(HEAT_PCT), .SCHED_NUM(SCHED_NUM),
        .SCHED_FLASH(SCHED_FLASH), .BUSY(BUSY));
    wsq_far_model wsq_far_model_inst (.clk(CORE_CLK), .init_cmd(init_cmd),
        .clr(clr), .weld_on(WELD_ON), .init_sw(INIT_SW),
        .line_sync(LINE_SYNC), .pulses(pulses));

    // 50 MHz clock
    initial begin
        forever #10 CORE_CLK = ~CORE_CLK;
    end

    // Ramp midpoints seen on the heat output, sampled mid-cycle
    always @(negedge CORE_CLK) begin
        if (HEAT_PCT === 8'h1e) seen_up <= 1'b1;
        if (HEAT_PCT === 8'h23) seen_dn <= 1'b1;
    end

    // Compare one value
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask : wr

    // Read data stand in the cycle after the strobe
    task automatic rd(input logic [10:0] a, input logic [7:0] e);
        @(posedge CORE_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1 chk("rdata", e, REG_RDATA);
    endtask : rd

    // Load one schedule, off and slope fields zero
    task automatic sched(input logic [5:0] n,
        input logic [7:0] sq, wl, pc, ho, im, co, va, cm);
        logic [7:0] v [11];
        v = '{sq, wl, pc, ho, 8'h00, im, co, va, cm, 8'h00, 8'h00};
        for (int f = 0; f < 11; f++) begin
            wr({1'b0, n, f[3:0]}, v[f]);
        end
    endtask : sched

    task automatic press();
        @(posedge CORE_CLK);
        init_cmd <= 1'b1;
        repeat (10) @(posedge CORE_CLK);
        init_cmd <= 1'b0;
    endtask : press

    // Bounded wait: k 0 busy, 1 flash, 2 schedule shown
    task automatic wait_on(input int k, input logic [5:0] v);
        int i;
        logic [5:0] c;
        for (i = 0; i < 6000; i++) begin
            @(posedge CORE_CLK);
            #1;
            c = (k == 0) ? BUSY : (k == 1) ? SCHED_FLASH : SCHED_NUM;
            if (c === v) break;
        end
        if (i == 6000) chk("wait", 8'(k), 8'hff);
    endtask : wait_on

    task automatic finish_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // Watchdog over the whole run
    initial begin
        repeat (60000) @(posedge CORE_CLK);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        rd(`WSQ_A_SEL, 8'h00);
        rd(`WSQ_A_STAT, 8'h00);
        rd(11'h4ff, 8'h00);
        // Chained pair, no hold then no squeeze
        sched(6'h01, 8'h01, 8'h02, 8'h3c, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02);
        sched(6'h02, 8'h00, 8'h02, 8'h28, 8'h01, 8'h01, 8'h00, 8'h04, 8'h00);
        wr(`WSQ_A_SEL, 8'h01);
        rd(`WSQ_A_SEL, 8'h01);
        clr <= 1'b1;
        press();
        clr <= 1'b0;
        wait_on(2, 6'h02);
        repeat (5) @(posedge CORE_CLK);
        chk("heat", 8'h28, HEAT_PCT);
        chk("valve", 8'h05, {5'h00, VALVE});
        chk("weld", 8'h01, {7'h00, WELD_ON});
        rd(`WSQ_A_STAT, 8'ha5);
        wait_on(0, 6'h00);
        chk("valve", 8'h00, {5'h00, VALVE});
        chk("pulses", 8'h01, pulses);
        // Successive pair
        sched(6'h03, 8'h01, 8'h01, 8'h3c, 8'h01, 8'h01, 8'h00, 8'h01, 8'h03);
        sched(6'h04, 8'h01, 8'h01, 8'h3c, 8'h01, 8'h01, 8'h00, 8'h02, 8'h00);
        wr(`WSQ_A_SEL, 8'h03);
        press();
        wait_on(1, 6'h01);
        chk("num", 8'h04, {2'b00, SCHED_NUM});
        repeat (200) @(posedge CORE_CLK);
        chk("busy", 8'h00, {7'h00, BUSY});
        press();
        wait_on(0, 6'h01);
        wait_on(0, 6'h00);
        chk("num", 8'h03, {2'b00, SCHED_NUM});
        rd(`WSQ_A_DISP, 8'h03);
        // Three impulses, third valve only
        sched(6'h05, 8'h01, 8'h01, 8'h50, 8'h01, 8'h03, 8'h01, 8'h04, 8'h00);
        wr(`WSQ_A_SEL, 8'h05);
        clr <= 1'b1;
        press();
        clr <= 1'b0;
        wait_on(0, 6'h01);
        repeat (5) @(posedge CORE_CLK);
        chk("valve", 8'h04, {5'h00, VALVE});
        wait_on(0, 6'h00);
        chk("pulses", 8'h03, pulses);
        // Upslope from zero, carried weld, downslope to the next percent
        sched(6'h06, 8'h01, 8'h01, 8'h3c, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02);
        wr({1'b0, 6'h06, `WSQ_F_SLM}, `WSQ_SL_UP);
        wr({1'b0, 6'h06, `WSQ_F_SLC}, 8'h02);
        sched(6'h07, 8'h00, 8'h01, 8'h3c, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02);
        wr({1'b0, 6'h07, `WSQ_F_SLM}, `WSQ_SL_DN);
        wr({1'b0, 6'h07, `WSQ_F_SLC}, 8'h02);
        sched(6'h08, 8'h00, 8'h01, 8'h0a, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00);
        wr(`WSQ_A_SEL, 8'h06);
        press();
        wait_on(2, 6'h08);
        wait_on(0, 6'h00);
        chk("upslope", 8'h01, {7'h00, seen_up});
        chk("downslope", 8'h01, {7'h00, seen_dn});
        chk("valve", 8'h00, {5'h00, VALVE});
        finish_test();
    end
endmodule : tb_weld_schedule_sequencer
